// *** hdl/pwm_ctrl_pkg.sv ***
`default_nettype none
package pwm_ctrl_pkg;
  // Clock rate and derived cycle counts
  localparam int CLK_HZ = 40000000;
  localparam int BLANK_NS = 350;
  // Least time rounds up
  localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Normal frequency: f_kHz = 65.0 * 100 / rt_kohm
  localparam int FREQ_CONST_X10 = 650;
  localparam int FREQ_SCALE = 100;
  // Nominal 65 kHz period at 40 MHz
  localparam int NOM_FREQ_KHZ = 65;
  localparam int NOM_PERIOD_CYC = CLK_HZ / (NOM_FREQ_KHZ * 1000);
  // Light-load frequency
  localparam int GREEN_FREQ_KHZ = 20;
  localparam int GREEN_PERIOD_CYC = CLK_HZ / (GREEN_FREQ_KHZ * 1000);
  // Duty limit percent
  localparam int MAX_DUTY_PCT = 75;
  // Overload delay: 60 ms at 65 kHz, as a period count
  localparam int OLP_DELAY_MS = 60;
  localparam int OLP_PERIODS = OLP_DELAY_MS * NOM_FREQ_KHZ;
  localparam int PER_W = 16;
  localparam int OLP_W = 13;
endpackage : pwm_ctrl_pkg
`default_nettype wire

// *** hdl/period_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Switching period counter: start pulse, duty limit and blanking window
module period_timer
  import pwm_ctrl_pkg::*;
#(
  parameter int W = PER_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic [W-1:0] period_i,
  output logic start_o,
  output logic duty_ok_o,
  output logic blank_o
);
  logic [W-1:0] cnt_q, cnt_d;
  logic [W-1:0] duty_lim;

  // Limit is 75 percent of the period, rounded down
  assign duty_lim = W'((32'(period_i) * MAX_DUTY_PCT) / 100);

  // Count wraps at period; idle at zero while stopped
  always_comb begin
    cnt_d = cnt_q;
    if (!run_i) begin
      cnt_d = '0;
    end else if (cnt_q >= period_i - W'(1)) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign start_o = run_i && (cnt_q == '0);
  assign duty_ok_o = cnt_q < duty_lim;
  assign blank_o = cnt_q < W'(BLANK_CYC);
endmodule : period_timer
`default_nettype wire

// *** hdl/green_mode_pwm_protection_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Lockout on at high, off at low
// - Below turn-on level, gate low, no pulses
// - Current-sense trip ends pulse this cycle
// - Ignore current sense during turn-on blanking
// - Gate forced low at 75 percent duty
// - Normal period from programming resistor value
// - Feedback below off level disables gate
// - Overvoltage shuts gate until next lockout-on
// - Overvoltage recovers automatically, hiccup if persisting
// - Sustained overload stops switching
// - Overload delay filters short feedback excursions
// - Pin faults turn gate off immediately
// - Overload delay counted in switching periods
// - Light load selects reduced frequency
module green_mode_pwm_protection_ctrl
  import pwm_ctrl_pkg::*;
#(
  parameter int OLP_COUNT = OLP_PERIODS,
  parameter int RT_W = 9
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic supply_above_on_i,
  input wire logic supply_below_off_i,
  input wire logic supply_overvoltage_i,
  input wire logic cs_trip_i,
  input wire logic fb_below_off_i,
  input wire logic fb_overload_i,
  input wire logic fb_light_load_i,
  input wire logic freq_program_pin_short_i,
  input wire logic freq_program_pin_open_i,
  input wire logic cs_pin_open_i,
  input wire logic [RT_W-1:0] rt_kohm_i,
  output logic gate_o,
  output logic running_o,
  output logic overvoltage_o,
  output logic overload_o
);
  typedef enum logic [1:0] {ST_LOCKOUT, ST_RUN, ST_OV_OFF, ST_OL_OFF} state_e;

  state_e state_q, state_d;
  logic gate_q, gate_d;
  logic [OLP_W-1:0] olp_q, olp_d;
  logic [PER_W-1:0] period;
  logic start, duty_ok, blank, run, fault_now;

  // Period from resistor; zero resistance falls back to nominal
  always_comb begin
    if (fb_light_load_i) begin
      period = PER_W'(GREEN_PERIOD_CYC);
    end else if (rt_kohm_i == '0) begin
      period = PER_W'(NOM_PERIOD_CYC);
    end else begin
      // Cycles = CLK_HZ * rt / (6500 * 1000) ... kHz form
      period = PER_W'((64'(CLK_HZ) * 64'(rt_kohm_i) * 10)
               / (64'(FREQ_CONST_X10) * FREQ_SCALE * 1000));
    end
  end

  period_timer #(
    .W(PER_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .run_i(run),
    .period_i(period),
    .start_o(start),
    .duty_ok_o(duty_ok),
    .blank_o(blank)
  );

  assign run = (state_q == ST_RUN);
  // Immediate gate kill conditions, not latched
  assign fault_now = fb_below_off_i || freq_program_pin_short_i
                     || freq_program_pin_open_i || cs_pin_open_i;

  // Protection state machine
  always_comb begin
    state_d = state_q;
    olp_d = olp_q;
    case (state_q)
      ST_LOCKOUT: begin
        olp_d = '0;
        if (supply_above_on_i) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (supply_below_off_i) begin
          state_d = ST_LOCKOUT;
        end else if (supply_overvoltage_i) begin
          state_d = ST_OV_OFF;
        end else if (!fb_overload_i) begin
          olp_d = '0;
        end else if (start) begin
          // Count periods, not clocks, so delay scales with frequency
          if (32'(olp_q) >= OLP_COUNT - 1) begin
            state_d = ST_OL_OFF;
          end else begin
            olp_d = olp_q + OLP_W'(1);
          end
        end
      end
      ST_OV_OFF: begin
        // Supply sags while off; restart at next turn-on
        if (supply_below_off_i) begin
          state_d = ST_LOCKOUT;
        end
      end
      ST_OL_OFF: begin
        if (supply_below_off_i) begin
          state_d = ST_LOCKOUT;
        end
      end
      default: state_d = ST_LOCKOUT;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_LOCKOUT;
      olp_q <= '0;
    end else begin
      state_q <= state_d;
      olp_q <= olp_d;
    end
  end

  // Gate pulse: set at start, reset by trip or duty limit
  always_comb begin
    gate_d = gate_q;
    if (state_d != ST_RUN || fault_now) begin
      gate_d = 1'b0;
    end else if (start) begin
      gate_d = 1'b1;
    end else if (!duty_ok) begin
      gate_d = 1'b0;
    end else if (cs_trip_i && !blank) begin
      gate_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  // Async kill keeps the fault path free of a clock delay
  // Overvoltage also cuts at once; the state catches up next edge
  assign gate_o = gate_q && !fault_now && !supply_overvoltage_i && run;
  assign running_o = run;
  assign overvoltage_o = (state_q == ST_OV_OFF);
  assign overload_o = (state_q == ST_OL_OFF);

  // Lockout and pulse shape checks
  a_lockout_gate_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_q == ST_LOCKOUT) |-> !gate_o)
    else $error("gate high during lockout");
  a_turn_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (state_q == ST_LOCKOUT && supply_above_on_i) |=> state_q == ST_RUN)
    else $error("no turn-on");
  a_run_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (run && supply_below_off_i) |=> !run)
    else $error("no lockout at low supply");
  a_gate_state: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !run |-> !gate_q)
    else $error("gate register high outside run");
  a_cs_trip_end: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (gate_q && cs_trip_i && !blank && !start) |=> !gate_q)
    else $error("current trip ignored");
  a_blank_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (gate_q && cs_trip_i && blank && duty_ok && !start && !fault_now
      && state_d == ST_RUN) |=> gate_q)
    else $error("blanking failed");
  a_duty_limit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!duty_ok && !start) |=> !gate_q)
    else $error("duty limit exceeded");
  a_fb_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    fb_below_off_i |-> !gate_o)
    else $error("gate on with feedback off");
  // Overvoltage checks
  a_ov_kill: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    supply_overvoltage_i |-> !gate_o)
    else $error("gate on during overvoltage");
  a_ov_stop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (run && supply_overvoltage_i && !supply_below_off_i) |=> overvoltage_o ##1 !gate_q)
    else $error("overvoltage not handled");
  a_ov_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (overvoltage_o && !supply_below_off_i) |=> overvoltage_o)
    else $error("overvoltage off left early");
  a_pin_fault: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (freq_program_pin_open_i || cs_pin_open_i || freq_program_pin_short_i) |-> !gate_o)
    else $error("gate on with pin fault");
  // Overload counter checks
  a_ol_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (run && !fb_overload_i && !supply_below_off_i && !supply_overvoltage_i)
      |=> (olp_q == '0))
    else $error("overload count not cleared");
  a_ol_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (run && (!start || !fb_overload_i || 32'(olp_q) < OLP_COUNT - 1)) |=> !overload_o)
    else $error("overload tripped early");
  a_ol_trip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (run && start && fb_overload_i && !supply_below_off_i && !supply_overvoltage_i
      && 32'(olp_q) >= OLP_COUNT - 1) |=> overload_o)
    else $error("overload did not trip");
  a_ol_gate_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    overload_o |-> !gate_o)
    else $error("gate on during overload");
  a_ol_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (overload_o && !supply_below_off_i) |=> overload_o)
    else $error("overload latch lost");
  a_gate_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (start && state_d == ST_RUN && !fault_now) |=> gate_q)
    else $error("no rise at period start");
endmodule : green_mode_pwm_protection_ctrl
`default_nettype wire

// *** verif/cs_sense_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Switch current stand-in: trips after a set on-time, zero never trips
module cs_sense_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic gate_i,
  input wire logic [15:0] trip_cyc_i,
  output logic cs_trip_o
);
  logic [15:0] on_q;
  // Current ramp modelled as an on-time count, cleared when the switch opens
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) on_q <= 16'h0000;
    else on_q <= gate_i ? on_q + 16'h0001 : 16'h0000;
  end
  // Trip also shows inside blanking, as a turn-on spike would
  assign cs_trip_o = gate_i && (trip_cyc_i != 16'h0000) && (on_q >= trip_cyc_i);
endmodule : cs_sense_model
`default_nettype wire

// *** verif/green_mode_pwm_protection_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module green_mode_pwm_protection_ctrl_test;
  import pwm_ctrl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic s_on = 1'b0, s_off = 1'b1, s_ov = 1'b0, fb_ol = 1'b0, fb_ll = 1'b0;
  logic [3:0] kill = 4'h0;
  logic [8:0] rt = 9'h064;
  logic [15:0] trip = 16'h0000;
  logic cs_trip, gate, run, ovo, olo;
  int n_mismatch = 0, checks_done = 0, n;
  // High time at 100 kohm, from the frequency formula and the duty limit
  localparam int HI_100 = 100 * (CLK_HZ / 10000) / FREQ_CONST_X10 * MAX_DUTY_PCT / 100;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Small overload count keeps the run short
  green_mode_pwm_protection_ctrl #(.OLP_COUNT(4)) green_mode_pwm_protection_ctrl_inst (
    .clk_i(clk), .rst_b_i(rst_b), .supply_above_on_i(s_on), .supply_below_off_i(s_off),
    .supply_overvoltage_i(s_ov), .cs_trip_i(cs_trip), .fb_below_off_i(kill[0]),
    .fb_overload_i(fb_ol), .fb_light_load_i(fb_ll), .freq_program_pin_short_i(kill[1]),
    .freq_program_pin_open_i(kill[2]), .cs_pin_open_i(kill[3]), .rt_kohm_i(rt),
    .gate_o(gate), .running_o(run), .overvoltage_o(ovo), .overload_o(olo));
  cs_sense_model cs_sense_model_inst (
    .clk_i(clk), .rst_b_i(rst_b), .gate_i(gate), .trip_cyc_i(trip), .cs_trip_o(cs_trip));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : chk
  task automatic wait_gate(input logic v);
    for (int i = 0; i < 3000 && gate !== v; i++) @(negedge clk);
  endtask : wait_gate
  // High time of the next whole pulse
  task automatic hi_time(output int c);
    c = 0;
    wait_gate(1'b0);
    wait_gate(1'b1);
    while (gate === 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
  endtask : hi_time
  // Drop below lockout-off, then rise past turn-on
  task automatic restart;
    @(posedge clk);
    s_off <= 1'b1;
    repeat (3) @(posedge clk);
    s_off <= 1'b0;
    s_on <= 1'b1;
    repeat (3) @(posedge clk);
    s_on <= 1'b0;
  endtask : restart
  task automatic t_lockout;
    repeat (20) @(negedge clk);
    chk("gate in lockout", 0, gate);
    restart();
    repeat (50) @(negedge clk);
    chk("running between levels", 1, run);
    @(posedge clk);
    s_off <= 1'b1;
    repeat (2) @(negedge clk);
    chk("running below off level", 0, run);
    chk("gate below off level", 0, gate);
    restart();
    repeat (50) @(negedge clk);
    chk("running after turn-on", 1, run);
    $display("lockout test done");
  endtask : t_lockout
  task automatic t_duty;
    int e;
    // Both ends of the advised frequency range
    for (int r = 50; r <= 100; r += 50) begin
      @(posedge clk);
      rt <= 9'(r);
      hi_time(n);
      hi_time(n);
      e = r * (CLK_HZ / 10000) / FREQ_CONST_X10 * MAX_DUTY_PCT / 100;
      chk("duty high time", 16'(e), n);
    end
    // Zero resistance falls back to the nominal period
    @(posedge clk);
    rt <= 9'h000;
    hi_time(n);
    hi_time(n);
    chk("nominal fallback high time", 16'(NOM_PERIOD_CYC * MAX_DUTY_PCT / 100), n);
    @(posedge clk);
    rt <= 9'h064;
    fb_ll <= 1'b1;
    hi_time(n);
    hi_time(n);
    chk("light load high time", 16'(GREEN_PERIOD_CYC * MAX_DUTY_PCT / 100), n);
    @(posedge clk);
    fb_ll <= 1'b0;
    $display("duty test done");
  endtask : t_duty
  task automatic t_sense;
    @(posedge clk);
    trip <= 16'h0005;
    hi_time(n);
    hi_time(n);
    chk("trip inside blanking", 1, 16'(n >= BLANK_CYC && n <= BLANK_CYC + 2));
    @(posedge clk);
    trip <= 16'h0064;
    hi_time(n);
    hi_time(n);
    chk("trip after blanking", 1, 16'(n >= 100 && n <= 102));
    @(posedge clk);
    trip <= 16'h0000;
    $display("sense test done");
  endtask : t_sense
  // Feedback pull-down and each pin fault in turn
  task automatic t_kill;
    for (int k = 0; k < 4; k++) begin
      wait_gate(1'b1);
      @(posedge clk);
      kill <= 4'h1 << k;
      @(negedge clk);
      chk("gate at kill", 0, gate);
      n = 0;
      repeat (1500) begin
        @(negedge clk);
        if (gate !== 1'b0) n++;
      end
      chk("gate while killed", 0, 16'(n));
      @(posedge clk);
      kill <= 4'h0;
      hi_time(n);
      chk("high time after release", 16'(HI_100), 16'(n));
    end
    $display("kill test done");
  endtask : t_kill
  task automatic t_ov;
    wait_gate(1'b1);
    @(posedge clk);
    s_ov <= 1'b1;
    @(negedge clk);
    chk("gate at overvoltage", 0, gate);
    @(posedge clk);
    s_ov <= 1'b0;
    repeat (1500) @(negedge clk);
    chk("overvoltage held", 1, {gate, ovo});
    @(posedge clk);
    s_ov <= 1'b1;
    restart();
    repeat (5) @(negedge clk);
    chk("hiccup trip", 1, {gate, ovo});
    @(posedge clk);
    s_ov <= 1'b0;
    restart();
    hi_time(n);
    chk("recovered high time", 16'(HI_100), 16'(n));
    $display("overvoltage test done");
  endtask : t_ov
  task automatic t_ol;
    @(posedge clk);
    fb_ol <= 1'b1;
    repeat (1300) @(negedge clk);
    @(posedge clk);
    fb_ol <= 1'b0;
    repeat (700) @(negedge clk);
    chk("short overload", 0, olo);
    @(posedge clk);
    fb_ol <= 1'b1;
    for (n = 0; n < 4000 && olo !== 1'b1; n++) @(negedge clk);
    chk("overload delay", 1,
        16'(n >= 3 * NOM_PERIOD_CYC && n <= 5 * NOM_PERIOD_CYC + 10));
    @(posedge clk);
    fb_ol <= 1'b0;
    repeat (2000) @(negedge clk);
    chk("overload latched", 1, {gate, olo});
    restart();
    @(negedge clk);
    chk("overload cleared", 2, {run, olo});
    $display("overload test done");
  endtask : t_ol
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_lockout();
    t_duty();
    t_sense();
    t_kill();
    t_ov();
    t_ol();
    give_verdict();
  end
  // Tests need about 30000 cycles
  initial begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
endmodule : green_mode_pwm_protection_ctrl_test
`default_nettype wire
